// ===== design/cpu_register_file_status.sv
// Register file, pointer pairs, status flags and interrupt gating of the CPU core
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps

module cpu_register_file_status
  import cpu_regfile_pkg::*;
(
  // Clock and reset
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_resetn,
  // Decoder register ports
  input  wire cpu_regfile_pkg::rf_req_t   i_rf_req,
  output logic [7:0]                      o_rd_a_data,
  output logic [7:0]                      o_rd_b_data,
  output logic [15:0]                     o_rd_pair_data,
  // ALU flags
  input  wire cpu_regfile_pkg::flag_upd_t i_flag_upd,
  // Bit copy
  input  wire cpu_regfile_pkg::bitcopy_req_t i_bitcopy,
  // Pointer access
  input  wire cpu_regfile_pkg::ptr_req_t  i_ptr_req,
  output logic [15:0]                     o_ptr_addr,
  output logic [15:0]                     o_lpm_addr,
  // Data-space access
  input  wire cpu_regfile_pkg::ds_req_t   i_ds_req,
  output logic [7:0]                      o_ds_rdata,
  output logic                            o_io_sel,
  output logic [5:0]                      o_io_addr,
  input  wire logic [7:0]                 i_io_rdata,
  // Interrupt control
  input  wire logic                       i_set_global_enable_instr,
  input  wire logic                       i_clear_global_enable_instr,
  input  wire logic                       i_return_from_interrupt_instr,
  input  wire logic                       i_call_push,
  input  wire logic [15:0]                i_return_pc,
  input  wire logic [7:0]                 i_irq_pending,
  output logic                            o_irq_take,
  output logic [2:0]                      o_irq_vector,
  output logic                            o_push_en,
  output logic [15:0]                     o_push_addr,
  output logic [15:0]                     o_push_data,
  output logic [15:0]                     o_stack_pointer,
  output logic [7:0]                      o_status,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr
);

  logic [7:0]  regs_q [NUM_REGS];
  logic [7:0]  cpu_status_flags_q;
  logic [15:0] stack_pointer_q;
  logic [7:0]  irq_hold_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  logic [15:0] ptr_cur;
  logic [15:0] ptr_new;
  logic [4:0]  ptr_lo;
  logic        ds_is_reg;
  logic        ds_is_io;
  logic        irq_any;
  logic [2:0]  irq_idx;
  logic        apb_acc;
  logic        apb_wr_status;
  logic        ds_wr_status;
  logic [7:0]  ds_status_val;

  function automatic logic [15:0] read_pair(input logic [4:0] lo);
    read_pair = {regs_q[lo + 5'h01], regs_q[lo]};
  endfunction : read_pair

  // Combinational reads give single-cycle operand access
  assign o_rd_a_data    = regs_q[i_rf_req.rd_a];
  assign o_rd_b_data    = regs_q[i_rf_req.rd_b];
  assign o_rd_pair_data = read_pair({i_rf_req.rd_a[4:1], 1'b0});

  // Pointer selection and auto-update
  assign ptr_lo  = 5'(pair_base(i_ptr_req.sel));
  assign ptr_cur = read_pair(ptr_lo);
  always_comb begin
    case (i_ptr_req.mode)
      PTR_POST_INC: ptr_new = ptr_cur + 16'h0001;
      PTR_PRE_DEC:  ptr_new = ptr_cur - 16'h0001;
      default:      ptr_new = ptr_cur;
    endcase
  end
  assign o_ptr_addr = (i_ptr_req.mode == PTR_PRE_DEC) ? ptr_new : ptr_cur;
  assign o_lpm_addr = read_pair(PTR_Z_LO);

  // Data-space decode
  assign ds_is_reg = i_ds_req.en && (i_ds_req.addr <= DS_REG_LAST);
  assign ds_is_io  = i_ds_req.en && (i_ds_req.addr >= DS_IO_FIRST)
                     && (i_ds_req.addr <= DS_IO_LAST);
  assign o_io_addr = 6'(i_ds_req.addr - DS_IO_FIRST);
  // Status and stack pointer live here; other I/O goes out
  assign o_io_sel  = ds_is_io && (o_io_addr != IO_STATUS)
                     && (o_io_addr != IO_SP_LO) && (o_io_addr != IO_SP_HI);
  always_comb begin
    if (ds_is_reg) begin
      o_ds_rdata = regs_q[i_ds_req.addr[4:0]];
    end else if (ds_is_io && o_io_addr == IO_STATUS) begin
      o_ds_rdata = cpu_status_flags_q;
    end else if (ds_is_io && o_io_addr == IO_SP_LO) begin
      o_ds_rdata = stack_pointer_q[7:0];
    end else if (ds_is_io && o_io_addr == IO_SP_HI) begin
      o_ds_rdata = stack_pointer_q[15:8];
    end else if (o_io_sel) begin
      o_ds_rdata = i_io_rdata;
    end else begin
      o_ds_rdata = 8'h00;
    end
  end
  assign ds_wr_status  = ds_is_io && i_ds_req.we && (o_io_addr == IO_STATUS);
  assign ds_status_val = i_ds_req.wdata;

  // Register file writes; later sources take priority
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else begin
      if (i_rf_req.wr8_en) begin
        regs_q[i_rf_req.wr8_addr] <= i_rf_req.wr8_data;
      end
      if (i_rf_req.wr16_en) begin
        regs_q[{i_rf_req.wr16_addr[4:1], 1'b0}] <= i_rf_req.wr16_data[7:0];
        regs_q[{i_rf_req.wr16_addr[4:1], 1'b1}] <= i_rf_req.wr16_data[15:8];
      end
      if (i_bitcopy.load) begin
        regs_q[i_bitcopy.reg_idx][i_bitcopy.bit_idx] <= cpu_status_flags_q[FLG_T];
      end
      if (ds_is_reg && i_ds_req.we) begin
        regs_q[i_ds_req.addr[4:0]] <= i_ds_req.wdata;
      end
      if (i_ptr_req.en && i_ptr_req.mode != PTR_PLAIN) begin
        regs_q[ptr_lo]           <= ptr_new[7:0];
        regs_q[ptr_lo + 5'h01]   <= ptr_new[15:8];
      end
    end
  end

  // Interrupt priority: lowest index is lowest vector
  always_comb begin
    irq_idx = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (i_irq_pending[k]) begin
        irq_idx = 3'(k);
      end
    end
  end
  assign irq_any      = |i_irq_pending;
  // Disable instruction in the same cycle blocks an interrupt; an enable admits one only from the next cycle
  assign o_irq_take   = irq_any && cpu_status_flags_q[FLG_I]
                        && !i_clear_global_enable_instr;
  assign o_irq_vector = irq_idx;

  // APB decode
  assign apb_acc       = psel && penable;
  assign apb_wr_status = apb_acc && pwrite && (paddr == APB_STATUS);
  assign pready        = 1'b1;

  // Status flags; hardware events follow software writes in priority
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      cpu_status_flags_q <= STATUS_RESET;
    end else begin
      // Flags are not touched on entry or return beyond bit 7
      if (apb_wr_status) begin
        cpu_status_flags_q <= pwdata[7:0];
      end else if (ds_wr_status) begin
        cpu_status_flags_q <= ds_status_val;
      end else begin
        if (i_flag_upd.en) begin
          if (i_flag_upd.mask[FLG_C]) cpu_status_flags_q[FLG_C] <= i_flag_upd.c;
          if (i_flag_upd.mask[FLG_Z]) cpu_status_flags_q[FLG_Z] <= i_flag_upd.z;
          if (i_flag_upd.mask[FLG_N]) cpu_status_flags_q[FLG_N] <= i_flag_upd.n;
          if (i_flag_upd.mask[FLG_V]) cpu_status_flags_q[FLG_V] <= i_flag_upd.v;
          if (i_flag_upd.mask[FLG_H]) cpu_status_flags_q[FLG_H] <= i_flag_upd.h;
          if (i_flag_upd.mask[FLG_S]) begin
            cpu_status_flags_q[FLG_S] <= i_flag_upd.n ^ i_flag_upd.v;
          end
        end
        if (i_bitcopy.store) begin
          cpu_status_flags_q[FLG_T] <= regs_q[i_bitcopy.reg_idx][i_bitcopy.bit_idx];
        end
        if (o_irq_take || i_clear_global_enable_instr) begin
          cpu_status_flags_q[FLG_I] <= 1'b0;
        end else if (i_return_from_interrupt_instr || i_set_global_enable_instr) begin
          cpu_status_flags_q[FLG_I] <= 1'b1;
        end
      end
    end
  end
  assign o_status = cpu_status_flags_q;

  // Stack: one 16-bit push at the current pointer, pointer drops by two, grows downward
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      stack_pointer_q <= STACK_TOP;
    end else begin
      if (ds_is_io && i_ds_req.we && o_io_addr == IO_SP_LO) begin
        stack_pointer_q[7:0] <= i_ds_req.wdata;
      end else if (ds_is_io && i_ds_req.we && o_io_addr == IO_SP_HI) begin
        stack_pointer_q[15:8] <= i_ds_req.wdata;
      end else if (o_irq_take || i_call_push) begin
        stack_pointer_q <= stack_pointer_q - 16'h0002;
      end
    end
  end
  assign o_push_en       = o_irq_take || i_call_push;
  assign o_push_addr     = stack_pointer_q;
  assign o_push_data     = i_return_pc;
  assign o_stack_pointer = stack_pointer_q;

  // Interrupt pending snapshot for software
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      irq_hold_q <= 8'h00;
    end else begin
      irq_hold_q <= i_irq_pending;
    end
  end

  // APB read data and error
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= 1'b0;
      case (paddr)
        APB_STATUS: prdata_q <= {24'h00_0000, cpu_status_flags_q};
        APB_CTRL:   prdata_q <= {16'h0000, stack_pointer_q};
        APB_IRQ_LO: prdata_q <= {24'h00_0000, irq_hold_q};
        default: begin
          prdata_q  <= 32'h0000_0000;
          pslverr_q <= 1'b1;
        end
      endcase
    end
  end
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q && apb_acc;

endmodule : cpu_register_file_status

// ===== include/cpu_regfile_pkg.sv
// Package: constants and carrier types for the CPU register file and status block
package cpu_regfile_pkg;

  // Register file geometry
  localparam int unsigned NUM_REGS     = 32;
  localparam int unsigned REG_AW       = 5;
  localparam logic [4:0]  PTR_X_LO     = 5'h1A;
  localparam logic [4:0]  PTR_Y_LO     = 5'h1C;
  localparam logic [4:0]  PTR_Z_LO     = 5'h1E;

  // Data-space map
  localparam logic [15:0] DS_REG_LAST  = 16'h001F;
  localparam logic [15:0] DS_IO_FIRST  = 16'h0020;
  localparam logic [15:0] DS_IO_LAST   = 16'h005F;
  localparam logic [5:0]  IO_STATUS    = 6'h3F;
  localparam logic [5:0]  IO_SP_LO     = 6'h3D;
  localparam logic [5:0]  IO_SP_HI     = 6'h3E;

  // Status flag positions
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;
  localparam int unsigned FLG_T = 6;
  localparam int unsigned FLG_I = 7;

  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [15:0] STACK_TOP    = 16'h025F;

  // APB register map (byte addresses)
  localparam logic [7:0]  APB_STATUS   = 8'h00;
  localparam logic [7:0]  APB_CTRL     = 8'h04;
  localparam logic [7:0]  APB_IRQ_LO   = 8'h08;

  // Pointer access modes
  typedef enum logic [1:0] {
    PTR_PLAIN,
    PTR_POST_INC,
    PTR_PRE_DEC
  } ptr_mode_t;

  typedef enum logic [1:0] {
    SEL_X,
    SEL_Y,
    SEL_Z
  } ptr_sel_t;

  // Register file port request from the decoder
  typedef struct packed {
    logic [4:0]  rd_a;
    logic [4:0]  rd_b;
    logic        wr8_en;
    logic [4:0]  wr8_addr;
    logic [7:0]  wr8_data;
    logic        wr16_en;
    logic [4:0]  wr16_addr;
    logic [15:0] wr16_data;
  } rf_req_t;

  // ALU flag update
  typedef struct packed {
    logic       en;
    logic [7:0] mask;
    logic       c;
    logic       z;
    logic       n;
    logic       v;
    logic       h;
  } flag_upd_t;

  // Pointer access request
  typedef struct packed {
    logic      en;
    ptr_sel_t  sel;
    ptr_mode_t mode;
  } ptr_req_t;

  // Data-space access request
  typedef struct packed {
    logic        en;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ds_req_t;

  // Bit copy request
  typedef struct packed {
    logic       store;
    logic       load;
    logic [4:0] reg_idx;
    logic [2:0] bit_idx;
  } bitcopy_req_t;

  function automatic logic [15:0] pair_base(input ptr_sel_t sel);
    case (sel)
      SEL_X:   pair_base = {11'h000, PTR_X_LO};
      SEL_Y:   pair_base = {11'h000, PTR_Y_LO};
      default: pair_base = {11'h000, PTR_Z_LO};
    endcase
  endfunction : pair_base

endpackage : cpu_regfile_pkg

// ===== dv/cpu_io_partner.sv
// Peripheral stand-in answering I/O reads of the data-space window
`timescale 1ns/10ps
module cpu_io_partner (
  // Clock and select
  input  wire logic       i_ref_clk,
  input  wire logic       i_io_sel,
  input  wire logic [5:0] i_io_addr,
  // Read data
  output logic [7:0]      o_io_rdata
);
  logic [7:0] junk_q = 8'h55;
  // Toggles every cycle so stale data never matches a reply, except 8'hAA against address 6'h2A
  always_ff @(posedge i_ref_clk) begin
    junk_q <= ~junk_q;
  end
  assign o_io_rdata = i_io_sel ? {2'b10, i_io_addr} : junk_q;
endmodule : cpu_io_partner

// ===== dv/cpu_regfile_sva.sv
// Port assertions for the CPU register file and status block
`timescale 1ns/10ps
module cpu_regfile_sva
  import cpu_regfile_pkg::*;
(
  // Clock and reset
  input wire logic                       i_ref_clk,
  input wire logic                       i_resetn,
  // Core requests
  input wire cpu_regfile_pkg::flag_upd_t i_flag_upd,
  input wire cpu_regfile_pkg::ptr_req_t  i_ptr_req,
  input wire cpu_regfile_pkg::ds_req_t   i_ds_req,
  input wire logic                       i_clear_global_enable_instr,
  input wire logic                       i_return_from_interrupt_instr,
  input wire logic [7:0]                 i_irq_pending,
  input wire logic [15:0]                i_return_pc,
  // Block outputs
  input wire logic [15:0]                o_ptr_addr,
  input wire logic [15:0]                o_lpm_addr,
  input wire logic                       o_irq_take,
  input wire logic [2:0]                 o_irq_vector,
  input wire logic                       o_push_en,
  input wire logic [15:0]                o_push_addr,
  input wire logic [15:0]                o_push_data,
  input wire logic [15:0]                o_stack_pointer,
  input wire logic [7:0]                 o_status,
  // Register bus
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr
);
  logic sw;
  // Software status writes beat every hardware flag source
  assign sw = (psel && penable && pwrite && paddr == APB_STATUS) ||
              (i_ds_req.en && i_ds_req.we && i_ds_req.addr == 16'h005F);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_sign_xor: assert property (i_flag_upd.en && i_flag_upd.mask[FLG_S] && !sw |=>
    o_status[FLG_S] == ($past(i_flag_upd.n) ^ $past(i_flag_upd.v)))
    else $error("sign flag differs from negative xor overflow");
  a_irq_gate: assert property (o_irq_take |-> o_status[FLG_I] &&
    i_irq_pending != 8'h00 && !i_clear_global_enable_instr)
    else $error("interrupt taken while globally disabled");
  a_take_clears: assert property (o_irq_take && !sw |=> !o_status[FLG_I])
    else $error("global enable still set after interrupt taken");
  a_return_from_interrupt_instr_sets: assert property (i_return_from_interrupt_instr && !o_irq_take &&
    !i_clear_global_enable_instr && !sw |=> o_status[FLG_I])
    else $error("return from interrupt left global enable clear");
  a_vector_low: assert property (o_irq_take |-> i_irq_pending[o_irq_vector] &&
    (i_irq_pending & ((8'h01 << o_irq_vector) - 8'h01)) == 8'h00)
    else $error("interrupt vector is not the lowest pending");
  a_push_frame: assert property (o_push_en |->
    o_push_addr == o_stack_pointer && o_push_data == i_return_pc)
    else $error("push address or data wrong");
  a_sp_down: assert property (o_push_en && !(i_ds_req.en && i_ds_req.we) |=>
    o_stack_pointer == $past(o_stack_pointer) - 16'h0002)
    else $error("stack pointer did not drop by two on push");
  a_post_inc: assert property (i_ptr_req.en && i_ptr_req.sel == SEL_Z &&
    i_ptr_req.mode == PTR_POST_INC |=> o_lpm_addr == $past(o_ptr_addr) + 16'h0001)
    else $error("table pointer not incremented after access");

  c_irq_take: cover property (o_irq_take);
  c_call_push: cover property (o_push_en && !o_irq_take);
  c_pre_dec: cover property (i_ptr_req.en && i_ptr_req.mode == PTR_PRE_DEC);
endmodule : cpu_regfile_sva

bind cpu_register_file_status cpu_regfile_sva u_sva (
  .i_ref_clk, .i_resetn, .i_flag_upd, .i_ptr_req, .i_ds_req, .i_clear_global_enable_instr,
  .i_return_from_interrupt_instr, .i_irq_pending, .i_return_pc, .o_ptr_addr, .o_lpm_addr,
  .o_irq_take, .o_irq_vector, .o_push_en, .o_push_addr, .o_push_data, .o_stack_pointer,
  .o_status, .psel, .penable, .pwrite, .paddr
);

// ===== dv/cpu_register_file_status_tb_top.sv
// Self-checking bench for the CPU register file and status block
`timescale 1ns/10ps
module cpu_register_file_status_tb_top;
  import cpu_regfile_pkg::*;
  logic         i_ref_clk = 1'b0;
  logic         i_resetn = 1'b0;
  rf_req_t      i_rf_req = '0;
  flag_upd_t    i_flag_upd = '0;
  bitcopy_req_t i_bitcopy = '0;
  ptr_req_t     i_ptr_req = '0;
  ds_req_t      i_ds_req = '0;
  logic         i_set_global_enable_instr = 1'b0, i_clear_global_enable_instr = 1'b0;
  logic         i_return_from_interrupt_instr = 1'b0, i_call_push = 1'b0;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic         o_io_sel, o_irq_take, o_push_en;
  logic [15:0]  i_return_pc = 16'h1234, o_rd_pair_data, o_ptr_addr, o_lpm_addr;
  logic [15:0]  o_push_addr, o_push_data, o_stack_pointer;
  logic [7:0]   i_irq_pending = 8'h00, paddr = 8'h00, i_io_rdata, o_status;
  logic [7:0]   o_rd_a_data, o_rd_b_data, o_ds_rdata;
  logic [31:0]  pwdata = 32'h0000_0000, prdata, rd;
  logic [5:0]   o_io_addr;
  logic [2:0]   o_irq_vector;
  int           mismatches = 0, tests_run = 0, cyc = 0;

  always #25 i_ref_clk = ~i_ref_clk;

  cpu_register_file_status uut (
    .i_ref_clk, .i_resetn, .i_rf_req, .o_rd_a_data, .o_rd_b_data, .o_rd_pair_data,
    .i_flag_upd, .i_bitcopy, .i_ptr_req, .o_ptr_addr, .o_lpm_addr, .i_ds_req, .o_ds_rdata,
    .o_io_sel, .o_io_addr, .i_io_rdata, .i_set_global_enable_instr,
    .i_clear_global_enable_instr, .i_return_from_interrupt_instr, .i_call_push,
    .i_return_pc, .i_irq_pending, .o_irq_take, .o_irq_vector, .o_push_en, .o_push_addr,
    .o_push_data, .o_stack_pointer, .o_status, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr
  );
  cpu_io_partner peer (
    .i_ref_clk, .i_io_sel(o_io_sel), .i_io_addr(o_io_addr), .o_io_rdata(i_io_rdata)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // Whole run needs well under a thousand cycles
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic pe();
    @(posedge i_ref_clk);
  endtask : pe

  task automatic ne();
    @(negedge i_ref_clk);
  endtask : ne

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    pe();
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pe();
    penable <= 1'b1;
    pe();
    while (pready !== 1'b1) begin
      pe();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic t_apb();
    apb(1'b0, APB_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, APB_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_025F);
    apb(1'b0, APB_IRQ_LO, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, APB_STATUS, 32'h0000_00A5);
    apb(1'b0, APB_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_00A5);
    apb(1'b1, 8'h0C, 32'h0000_00FF);
    chk(32'(er), 32'h0000_0001);
    apb(1'b1, APB_STATUS, 32'h0000_0000);
  endtask : t_apb

  task automatic t_regs();
    for (int i = 0; i < 32; i++) begin
      pe();
      i_rf_req <= '{wr8_en: 1'b1, wr8_addr: 5'(i), wr8_data: 8'(i) ^ 8'h5A, default: '0};
    end
    for (int i = 0; i < 32; i++) begin
      pe();
      i_rf_req <= '{rd_a: 5'(i), default: '0};
      i_ds_req <= '{en: 1'b1, we: 1'b0, addr: 16'(i), wdata: 8'h00};
      ne();
      chk(32'(o_rd_a_data), 32'(8'(i) ^ 8'h5A));
      chk(32'(o_ds_rdata), 32'(8'(i) ^ 8'h5A));
    end
    pe();
    i_rf_req <= '{wr16_en: 1'b1, wr16_addr: 5'h1D, wr16_data: 16'hBEEF, default: '0};
    i_ds_req <= '{en: 1'b1, we: 1'b0, addr: 16'h0030, wdata: 8'h00};
    ne();
    chk(32'(o_ds_rdata), 32'h0000_0090);
    pe();
    i_rf_req <= '{rd_a: PTR_Y_LO, rd_b: 5'h1D, default: '0};
    ne();
    chk(32'(o_rd_pair_data), 32'h0000_BEEF);
    chk(32'(o_rd_b_data), 32'h0000_00BE);
  endtask : t_regs

  task automatic t_ptr();
    pe();
    i_rf_req <= '{wr16_en: 1'b1, wr16_addr: PTR_Z_LO, wr16_data: 16'h0040, default: '0};
    pe();
    i_rf_req <= '0;
    i_ptr_req <= '{en: 1'b1, sel: SEL_Z, mode: PTR_POST_INC};
    ne();
    chk(32'(o_lpm_addr), 32'h0000_0040);
    pe();
    i_ptr_req <= '{en: 1'b1, sel: SEL_X, mode: PTR_PRE_DEC};
    ne();
    chk(32'(o_lpm_addr), 32'h0000_0041);
    chk(32'(o_ptr_addr), 32'h0000_413F);
    pe();
    i_ptr_req <= '{en: 1'b0, sel: SEL_X, mode: PTR_PLAIN};
    i_rf_req <= '{rd_a: PTR_X_LO, default: '0};
    ne();
    chk(32'(o_rd_pair_data), 32'h0000_413F);
  endtask : t_ptr

  task automatic t_flags();
    pe();
    i_rf_req <= '0;
    i_flag_upd <= '{en: 1'b1, mask: 8'h3F, c: 1'b1, z: 1'b0, n: 1'b1, v: 1'b0, h: 1'b1};
    pe();
    i_flag_upd <= '{en: 1'b1, mask: 8'h01, default: '0};
    ne();
    chk(32'(o_status), 32'h0000_0035);
    pe();
    i_flag_upd <= '0;
    i_bitcopy <= '{store: 1'b1, load: 1'b0, reg_idx: 5'h05, bit_idx: 3'h6};
    ne();
    chk(32'(o_status), 32'h0000_0034);
    pe();
    i_bitcopy <= '{store: 1'b0, load: 1'b1, reg_idx: 5'h00, bit_idx: 3'h7};
    ne();
    chk(32'(o_status), 32'h0000_0074);
    pe();
    i_bitcopy <= '0;
    ne();
    chk(32'(o_rd_a_data), 32'h0000_00DA);
  endtask : t_flags

  task automatic t_irq();
    pe();
    i_irq_pending <= 8'h2C;
    ne();
    chk(32'(o_irq_take), 32'h0000_0000);
    pe();
    i_set_global_enable_instr <= 1'b1;
    pe();
    i_set_global_enable_instr <= 1'b0;
    ne();
    chk(32'(o_status), 32'h0000_00F4);
    chk(32'(o_irq_vector), 32'h0000_0002);
    chk({o_push_addr, o_push_data}, 32'h025F_1234);
    chk(32'(o_push_en), 32'h0000_0001);
    chk(32'(o_irq_take), 32'h0000_0001);
    pe();
    i_irq_pending <= 8'h00;
    ne();
    chk(32'(o_status), 32'h0000_0074);
    chk(32'(o_stack_pointer), 32'h0000_025D);
    pe();
    i_return_from_interrupt_instr <= 1'b1;
    pe();
    i_return_from_interrupt_instr <= 1'b0;
    i_clear_global_enable_instr <= 1'b1;
    i_irq_pending <= 8'h80;
    ne();
    chk(32'(o_status), 32'h0000_00F4);
    chk(32'(o_irq_take), 32'h0000_0000);
    pe();
    i_clear_global_enable_instr <= 1'b0;
    i_irq_pending <= 8'h00;
    i_call_push <= 1'b1;
    ne();
    chk(32'(o_status), 32'h0000_0074);
    pe();
    i_call_push <= 1'b0;
    ne();
    chk(32'(o_stack_pointer), 32'h0000_025B);
  endtask : t_irq

  // Data-space path: status read, register write, software status write beats ALU
  task automatic t_ds();
    pe();
    i_ds_req <= '{en: 1'b1, we: 1'b0, addr: 16'h005F, wdata: 8'h00};
    ne();
    chk(32'(o_ds_rdata), 32'h0000_0074);
    pe();
    i_ds_req <= '{en: 1'b1, we: 1'b1, addr: 16'h0003, wdata: 8'hC3};
    pe();
    i_ds_req <= '{en: 1'b1, we: 1'b1, addr: 16'h005F, wdata: 8'h81};
    i_flag_upd <= '{en: 1'b1, mask: 8'h01, default: '0};
    i_rf_req <= '{rd_a: 5'h03, default: '0};
    ne();
    chk(32'(o_rd_a_data), 32'h0000_00C3);
    pe();
    i_ds_req <= '{en: 1'b1, we: 1'b0, addr: 16'h005D, wdata: 8'h00};
    i_flag_upd <= '0;
    ne();
    chk(32'(o_status), 32'h0000_0081);
    chk(32'(o_ds_rdata), 32'h0000_005B);
    pe();
    i_ds_req <= '0;
  endtask : t_ds

  initial begin
    repeat (3) pe();
    i_resetn <= 1'b1;
    t_apb();
    t_regs();
    t_ptr();
    t_flags();
    t_irq();
    t_ds();
    test_done();
  end
endmodule : cpu_register_file_status_tb_top
